// ### design/mil_pkg.sv
// constants, types and register map of the interrupt logic
//
// Overview of operation
// - accept: push registers, set mask, load vector
// - return pulls registers in reverse push order
// - soft trap always interrupts, ignoring all masks
// - external interrupt blocked by mask or disable
// - enable bit RW, reset 0; 0=LED, 1=interrupt
// - check latch after each instruction completes
// - latch cleared at vector fetch, refills later
// - sense bit: 0 edge-and-level, 1 edge only
// - level mode: request persists while pin low
// - edge mode: rearm only after pin high
// - 16-bit timer sources masked by mask bit
// - capture flag: status read then low byte
// - compare flag: status read then low byte
// - overflow flag: status read then counter low
// - both timers wake from wait mode
// - 8-bit timer zero sets flag, enabled request
// - key falling edge sets flag, enable requests
// - key flag write-one-clear; reset clears all
// - keyboard wakes from wait and stop
// - per-pin pull-up from pull-up enable register
// - masked request stays latched until unmasked
// - fixed priority: ext, timer16, timer8, keyboard
package mil_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] KEY_EN_IDX   = 6'h0b;
  localparam logic [5:0] KEY_FLAG_IDX = 6'h0c;
  localparam logic [5:0] T8_CS_IDX    = 6'h0d;
  localparam logic [5:0] T16_CTL_IDX  = 6'h12;
  localparam logic [5:0] T16_STS_IDX  = 6'h13;
  localparam logic [5:0] MISC_IDX     = 6'h0e;
  localparam logic [5:0] PULLUP_IDX   = 6'h08;

  localparam logic [7:0] KEY_EN_ADDR   = {KEY_EN_IDX, 2'b00};
  localparam logic [7:0] KEY_FLAG_ADDR = {KEY_FLAG_IDX, 2'b00};
  localparam logic [7:0] T8_CS_ADDR    = {T8_CS_IDX, 2'b00};
  localparam logic [7:0] T16_CTL_ADDR  = {T16_CTL_IDX, 2'b00};
  localparam logic [7:0] T16_STS_ADDR  = {T16_STS_IDX, 2'b00};
  localparam logic [7:0] MISC_ADDR     = {MISC_IDX, 2'b00};
  localparam logic [7:0] PULLUP_ADDR   = {PULLUP_IDX, 2'b00};

  // field positions
  localparam int MISC_CAP_IE_BIT  = 7;
  localparam int MISC_CMP_IE_BIT  = 6;
  localparam int MISC_EXT_EN_BIT  = 1;
  localparam int MISC_SENSE_BIT   = 0;
  localparam int T8_FLAG_BIT      = 7;
  localparam int T8_IE_BIT        = 6;
  localparam int T8_RUN_BIT       = 3;
  localparam int T16_OVF_IE_BIT   = 5;
  localparam int STS_CAP_BIT      = 7;
  localparam int STS_CMP_BIT      = 6;
  localparam int STS_OVF_BIT      = 5;

  // values after reset
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [3:0] KEY_RST   = 4'h0;
  localparam logic [4:0] PIN_RST   = 5'h1f;

  // stack frame: five bytes, pushed low index first
  localparam logic [2:0] FRAME_LAST = 3'h4;
  localparam logic [2:0] FRAME_FIRST = 3'h0;

  // vector addresses
  localparam logic [15:0] VEC_SWI = 16'h1ffc;
  localparam logic [15:0] VEC_EXT = 16'h1ffa;
  localparam logic [15:0] VEC_T16 = 16'h1ff8;
  localparam logic [15:0] VEC_T8  = 16'h1ff6;
  localparam logic [15:0] VEC_KEY = 16'h1ff4;

  typedef enum logic [4:0] {
    MIL_IDLE = 5'b00001,
    MIL_PUSH = 5'b00010,
    MIL_SETI = 5'b00100,
    MIL_VEC  = 5'b01000,
    MIL_PULL = 5'b10000
  } mil_state_t;

  // stack strobe to the cpu core
  typedef struct packed {
    logic       push;
    logic       pull;
    logic [2:0] sel;
  } mil_stack_op_t;

endpackage : mil_pkg

// ### design/mil_intc.sv
// interrupt gathering, sequencing and register file of the mcu
//
// The APB interface to the registers was left to the implementer.
module mil_intc
  import mil_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // cpu core
  input  wire logic          cpu_imask,
  input  wire logic          instr_done,
  input  wire logic          swi_exec,
  input  wire logic          rti_exec,
  input  wire logic          cpu_wait,
  input  wire logic          cpu_stop,
  output mil_stack_op_t      stack_op,
  output logic               set_mask,
  output logic               vector_fetch,
  output logic      [15:0]   vector_addr,
  output logic               seq_busy,
  output logic               wake,
  // timer events
  input  wire logic          capture_evt,
  input  wire logic          compare_evt,
  input  wire logic          overflow_evt,
  input  wire logic          t8_zero_evt,
  input  wire logic          capture_low_rd,
  input  wire logic          compare_low_acc,
  input  wire logic          counter_low_acc,
  output logic               t8_run,
  // pins
  input  wire logic          shared_led_int_pin_i,
  output logic               shared_led_int_pin_o,
  output logic               shared_led_int_pin_oe,
  input  wire logic          led_on,
  input  wire logic [3:0]    keyboard_pins,
  output logic      [7:0]    pullup_en
);

  function automatic logic [4:0] fall(input logic [4:0] prev,
                                      input logic [4:0] cur);
    fall = prev & ~cur;
  endfunction

  logic [4:0]    s1_reg, s2_reg, s3_reg, pin_reg, pin_prev_reg;
  logic [7:0]    misc_reg, t8cs_reg, pullup_enable_reg;
  logic [5:0]    misc_lo_reg;
  logic [1:0]    misc_ie_reg;
  logic [3:0]    key_enable_reg, key_flag_reg;
  logic          ovf_ie_reg;
  logic          cap_flag_reg, cmp_flag_reg, ovf_flag_reg;
  logic          cap_arm_reg, cmp_arm_reg, ovf_arm_reg;
  logic          ext_latch_reg, ext_armed_reg;
  mil_state_t    state_reg;
  logic [2:0]    cnt_reg;
  logic          src_ext_reg;
  logic [15:0]   vec_reg;
  logic [31:0]   rdata_reg;
  logic          err_reg;

  logic          wr_en, rd_acc, setup, mapped;
  logic [4:0]    pin_fall;
  logic          ext_set, ext_req, t16_req, t8_req, key_req, any_req;
  logic [3:0]    key_w1c;
  logic          ext_en, sense_edge;

  assign misc_reg   = {misc_ie_reg, misc_lo_reg};
  assign ext_en     = misc_reg[MISC_EXT_EN_BIT];
  assign sense_edge = misc_reg[MISC_SENSE_BIT];

  // ---------------- apb slave: zero wait states ----------------
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pready  = psel & penable;
  assign prdata  = rdata_reg;
  assign pslverr = err_reg & psel & penable;
  assign mapped  = paddr inside {KEY_EN_ADDR, KEY_FLAG_ADDR, T8_CS_ADDR,
                                 T16_CTL_ADDR, T16_STS_ADDR, MISC_ADDR,
                                 PULLUP_ADDR};

  // read data captured in setup so it leaves a flip-flop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (setup) begin
      err_reg <= ~mapped;
      case (paddr)
        KEY_EN_ADDR:   rdata_reg <= {28'h0, key_enable_reg};
        KEY_FLAG_ADDR: rdata_reg <= {28'h0, key_flag_reg};
        T8_CS_ADDR:    rdata_reg <= {24'h0, t8cs_reg};
        T16_CTL_ADDR:  rdata_reg <= {26'h0, ovf_ie_reg, 5'h00};
        T16_STS_ADDR:  rdata_reg <= {24'h0, cap_flag_reg, cmp_flag_reg,
                                     ovf_flag_reg, 5'h00};
        MISC_ADDR:     rdata_reg <= {24'h0, misc_reg};
        PULLUP_ADDR:   rdata_reg <= {24'h0, pullup_enable_reg};
        default:       rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      misc_lo_reg <= BYTE_RST[5:0];
    end else if (wr_en && paddr == MISC_ADDR) begin
      misc_lo_reg <= pwdata[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en && paddr == MISC_ADDR) begin
      misc_ie_reg <= pwdata[7:6];
    end
    if (wr_en && paddr == T16_CTL_ADDR) begin
      ovf_ie_reg <= pwdata[T16_OVF_IE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pullup_enable_reg <= BYTE_RST;
    end else if (wr_en && paddr == PULLUP_ADDR) begin
      pullup_enable_reg <= pwdata[7:0];
    end
  end
  assign pullup_en = pullup_enable_reg;

  // timer8 enable and flag; event beats a clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      t8cs_reg <= BYTE_RST;
    end else begin
      if (wr_en && paddr == T8_CS_ADDR) begin
        t8cs_reg[6:0] <= pwdata[6:0];
      end
      if (t8_zero_evt) begin
        t8cs_reg[T8_FLAG_BIT] <= 1'b1;
      end else if (wr_en && paddr == T8_CS_ADDR && pwdata[T8_FLAG_BIT]) begin
        t8cs_reg[T8_FLAG_BIT] <= 1'b0;
      end
    end
  end
  assign t8_run = t8cs_reg[T8_RUN_BIT];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      key_enable_reg <= KEY_RST;
    end else if (wr_en && paddr == KEY_EN_ADDR) begin
      key_enable_reg <= pwdata[3:0];
    end
  end

  // ---------------- pin synchronisers ----------------
  // three stages; a level counts once stages two and three agree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg       <= PIN_RST;
      s2_reg       <= PIN_RST;
      s3_reg       <= PIN_RST;
      pin_reg      <= PIN_RST;
      pin_prev_reg <= PIN_RST;
    end else begin
      s1_reg       <= {shared_led_int_pin_i, keyboard_pins};
      s2_reg       <= s1_reg;
      s3_reg       <= s2_reg;
      pin_reg      <= (s2_reg & ~(s2_reg ^ s3_reg)) |
                      (pin_reg & (s2_reg ^ s3_reg));
      pin_prev_reg <= pin_reg;
    end
  end
  assign pin_fall = fall(pin_prev_reg, pin_reg);

  // ---------------- keyboard flags ----------------
  assign key_w1c = (wr_en && paddr == KEY_FLAG_ADDR) ? pwdata[3:0] : 4'h0;

  // falling edge sets flag, beating a clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      key_flag_reg <= KEY_RST;
    end else begin
      key_flag_reg <= (key_flag_reg & ~key_w1c) | pin_fall[3:0];
    end
  end

  // ---------------- 16-bit timer flags ----------------
  // status read with flag set arms; the low-byte access then clears
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cap_flag_reg <= 1'b0;
      cmp_flag_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      cap_arm_reg  <= 1'b0;
      cmp_arm_reg  <= 1'b0;
      ovf_arm_reg  <= 1'b0;
    end else begin
      if (rd_acc && paddr == T16_STS_ADDR) begin
        cap_arm_reg <= cap_flag_reg;
        cmp_arm_reg <= cmp_flag_reg;
        ovf_arm_reg <= ovf_flag_reg;
      end
      if (capture_evt) begin
        cap_flag_reg <= 1'b1;
      end else if (capture_low_rd && cap_arm_reg) begin
        cap_flag_reg <= 1'b0;
        cap_arm_reg  <= 1'b0;
      end
      if (compare_evt) begin
        cmp_flag_reg <= 1'b1;
      end else if (compare_low_acc && cmp_arm_reg) begin
        cmp_flag_reg <= 1'b0;
        cmp_arm_reg  <= 1'b0;
      end
      if (overflow_evt) begin
        ovf_flag_reg <= 1'b1;
      end else if (counter_low_acc && ovf_arm_reg) begin
        ovf_flag_reg <= 1'b0;
        ovf_arm_reg  <= 1'b0;
      end
    end
  end

  // ---------------- external request latch ----------------
  // sense select chooses edge or edge-and-level
  // in level mode (sense bit 0) a low level keeps setting the latch
  assign ext_set = ext_en && (sense_edge ? (pin_fall[4] && ext_armed_reg)
                                         : !pin_reg[4]);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_latch_reg <= 1'b0;
      ext_armed_reg <= 1'b1;
    end else begin
      // rearm only once pin is back high
      if (pin_reg[4]) begin
        ext_armed_reg <= 1'b1;
      end else if (ext_set) begin
        ext_armed_reg <= 1'b0;
      end
      // vector fetch clears; a new request wins
      if (ext_set) begin
        ext_latch_reg <= 1'b1;
      end else if (state_reg == MIL_VEC && src_ext_reg) begin
        ext_latch_reg <= 1'b0;
      end
    end
  end

  // open drain: pulls low only in led role
  assign shared_led_int_pin_o  = 1'b0;
  assign shared_led_int_pin_oe = !ext_en && led_on;

  // ---------------- request gathering ----------------
  // blocked when disabled; mask checked at acceptance
  assign ext_req = ext_latch_reg && ext_en;
  // three timer16 sources share one vector
  assign t16_req = (cap_flag_reg && misc_reg[MISC_CAP_IE_BIT]) ||
                   (cmp_flag_reg && misc_reg[MISC_CMP_IE_BIT]) ||
                   (ovf_flag_reg && ovf_ie_reg);
  assign t8_req  = t8cs_reg[T8_FLAG_BIT] && t8cs_reg[T8_IE_BIT];
  assign key_req = |(key_flag_reg & key_enable_reg);
  assign any_req = ext_req || t16_req || t8_req || key_req;

  // timers wake from wait; keys from stop too
  assign wake = (cpu_wait && any_req) || (cpu_stop && (key_req || ext_req));

  // ---------------- service sequencer ----------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= MIL_IDLE;
      cnt_reg     <= FRAME_FIRST;
      src_ext_reg <= 1'b0;
      vec_reg     <= VEC_SWI;
    end else begin
      case (state_reg)
        MIL_IDLE: begin
          cnt_reg <= FRAME_FIRST;
          if (instr_done) begin
            if (swi_exec) begin
              state_reg   <= MIL_PUSH;
              vec_reg     <= VEC_SWI;
              src_ext_reg <= 1'b0;
            end else if (rti_exec) begin
              state_reg <= MIL_PULL;
              cnt_reg   <= FRAME_LAST;
            end else if (!cpu_imask && any_req) begin
              state_reg   <= MIL_PUSH;
              src_ext_reg <= ext_req;
              vec_reg     <= ext_req ? VEC_EXT :
                             t16_req ? VEC_T16 :
                             t8_req  ? VEC_T8  : VEC_KEY;
            end
          end
        end
        // push frame, then mask, then vector
        MIL_PUSH: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == FRAME_LAST) begin
            state_reg <= MIL_SETI;
          end
        end
        MIL_SETI: state_reg <= MIL_VEC;
        MIL_VEC:  state_reg <= MIL_IDLE;
        MIL_PULL: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == FRAME_FIRST) begin
            state_reg <= MIL_IDLE;
          end
        end
        default: state_reg <= MIL_IDLE;
      endcase
    end
  end

  assign stack_op = {state_reg == MIL_PUSH, state_reg == MIL_PULL, cnt_reg};
  assign set_mask      = state_reg == MIL_SETI;
  assign vector_fetch  = state_reg == MIL_VEC;
  assign vector_addr   = vec_reg;
  assign seq_busy      = state_reg != MIL_IDLE;

  // ---------------- assertions ----------------
  sequence seq_push_frame;
    stack_op.push[*5] ##1 set_mask ##1 vector_fetch;
  endsequence

  sequence seq_pull_frame;
    stack_op.sel == 3'h4 ##1 stack_op.sel == 3'h3 ##1 stack_op.sel == 3'h2
      ##1 stack_op.sel == 3'h1 ##1 stack_op.sel == 3'h0 ##1 !stack_op.pull;
  endsequence

  AST_PUSH_ORDER: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(stack_op.push) |-> seq_push_frame)
    else $error("push, mask, vector order broken");
  AST_PULL_ORDER: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(stack_op.pull) |-> seq_pull_frame)
    else $error("pull order is not reverse of push");
  AST_SOFT_TRAP: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == MIL_IDLE && instr_done && swi_exec)
      |=> stack_op.push && vector_addr == VEC_SWI)
    else $error("soft trap not taken");
  AST_EXT_BLOCK: assert property (@(posedge core_clk) disable iff (!nrst)
    ($rose(stack_op.push) && src_ext_reg)
      |-> !$past(cpu_imask) && $past(ext_en))
    else $error("external taken while blocked");
  AST_EXT_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    (vector_fetch && src_ext_reg && !ext_set) |=> !ext_latch_reg)
    else $error("latch not cleared at vector fetch");

  AST_LEVEL_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    (ext_en && !sense_edge && !pin_reg[4]) |=> ext_latch_reg)
    else $error("low level not latched");

  AST_EDGE_ONLY: assert property (@(posedge core_clk) disable iff (!nrst)
    ($rose(ext_latch_reg) && $past(sense_edge)) |-> $past(pin_fall[4]))
    else $error("edge mode latched without a fall");

  AST_KEY_SET: assert property (@(posedge core_clk) disable iff (!nrst)
    (pin_fall[3:0] != 4'h0)
      |=> (key_flag_reg & $past(pin_fall[3:0])) == $past(pin_fall[3:0]))
    else $error("key edge did not set flag");

  AST_KEY_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    (key_w1c != 4'h0 && pin_fall[3:0] == 4'h0)
      |=> (key_flag_reg & $past(key_w1c)) == 4'h0)
    else $error("write one did not clear key flag");

  AST_PRIORITY: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == MIL_IDLE && instr_done && !swi_exec && !rti_exec
      && !cpu_imask && ext_req) |=> vector_addr == VEC_EXT)
    else $error("external not given top priority");

  AST_WAKE_KEY: assert property (@(posedge core_clk) disable iff (!nrst)
    (cpu_stop && key_req) |-> wake)
    else $error("keyboard failed to wake from stop");

endmodule // mil_intc

// ### test/mil_cpu_model.sv
// behavioural cpu core model facing the interrupt sequencer
module mil_cpu_model
  import mil_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          seq_busy,
  input  wire logic          set_mask,
  input  wire mil_stack_op_t stack_op,
  input  wire logic          swi_req,
  input  wire logic          rti_req,
  input  wire logic          sei_req,
  input  wire logic          cli_req,
  output logic               instr_done,
  output logic               swi_exec,
  output logic               rti_exec,
  output logic               cpu_imask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_reg;
  logic       saved_mask_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg  <= 2'h0;
      instr_done <= 1'b0;
    end else begin
      phase_reg  <= phase_reg + 2'h1;
      instr_done <= (phase_reg == 2'h3) && !seq_busy;
    end
  end

  assign swi_exec = instr_done & swi_req;
  assign rti_exec = instr_done & rti_req & ~swi_req;

  // mask saved in frame, set, restored
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_imask      <= 1'b1;
      saved_mask_reg <= 1'b1;
    end else begin
      if (stack_op.push && stack_op.sel == 3'h4) begin
        saved_mask_reg <= cpu_imask;
      end
      if (set_mask || sei_req) begin
        cpu_imask <= 1'b1;
      end else if (stack_op.pull && stack_op.sel == 3'h4) begin
        cpu_imask <= saved_mask_reg;
      end else if (cli_req) begin
        cpu_imask <= 1'b0;
      end
    end
  end
endmodule // mil_cpu_model

// ### test/testbench.sv
// self-checking bench for the interrupt logic
module testbench
  import mil_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RA [5] = '{KEY_EN_ADDR, KEY_FLAG_ADDR, T8_CS_ADDR,
                                    MISC_ADDR, PULLUP_ADDR};
  logic          core_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]    paddr, pullup_en;
  logic [31:0]   pwdata, prdata, rnd;
  logic          imask, idone, swi_x, rti_x, swi_req, rti_req;
  logic          sei_req, cli_req, cpu_wait, cpu_stop, set_mask, vfetch;
  logic          busy, wake, t8_run, led_on, ext_drv, pin_i, pin_o, pin_oe;
  logic [3:0]    evt, keys;
  logic [2:0]    acc;
  logic [15:0]   vaddr;
  mil_stack_op_t sop;
  logic [32:0]   rdq [$];
  logic [15:0]   vq [$];
  int            errors, compares, cyc, pc, pl;

  // open-drain pin: low whenever the block pulls it
  assign pin_i = ext_drv & ~pin_oe;

  mil_intc dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_imask(imask),
    .instr_done(idone), .swi_exec(swi_x), .rti_exec(rti_x),
    .cpu_wait(cpu_wait), .cpu_stop(cpu_stop), .stack_op(sop),
    .set_mask(set_mask), .vector_fetch(vfetch), .vector_addr(vaddr),
    .seq_busy(busy), .wake(wake), .capture_evt(evt[0]),
    .compare_evt(evt[1]), .overflow_evt(evt[2]), .t8_zero_evt(evt[3]),
    .capture_low_rd(acc[0]), .compare_low_acc(acc[1]),
    .counter_low_acc(acc[2]), .t8_run(t8_run), .shared_led_int_pin_i(pin_i),
    .shared_led_int_pin_o(pin_o), .shared_led_int_pin_oe(pin_oe),
    .led_on(led_on), .keyboard_pins(keys), .pullup_en(pullup_en));

  mil_cpu_model cpu_u (.core_clk(core_clk), .nrst(nrst), .seq_busy(busy),
    .set_mask(set_mask), .stack_op(sop), .swi_req(swi_req),
    .rti_req(rti_req), .sei_req(sei_req), .cli_req(cli_req),
    .instr_done(idone), .swi_exec(swi_x), .rti_exec(rti_x),
    .cpu_imask(imask));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] e,
                     input logic [32:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rdq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_q(input int n);
    for (int i = 0; i < 300 && vq.size() > n; i++) @(posedge core_clk);
    if (vq.size() > n) chk("vec_late", 33'h0, 33'h1);
  endtask

  // s=1 soft trap, s=0 return; held until the core takes it
  task automatic cpu(input logic s);
    int i;
    i = 0;
    if (s) swi_req <= 1'b1;
    else rti_req <= 1'b1;
    do begin
      @(posedge core_clk);
      i++;
    end while (!(idone && (s ? swi_x : rti_x)) && i < 200);
    if (i >= 200) chk("cpu_take", 33'h0, 33'h1);
    swi_req <= 1'b0;
    rti_req <= 1'b0;
    tick(8);
  endtask

  task automatic mask(input logic s);
    if (s) sei_req <= 1'b1;
    else cli_req <= 1'b1;
    @(posedge core_clk);
    sei_req <= 1'b0;
    cli_req <= 1'b0;
  endtask

  task automatic strobe(input int i, input logic a);
    if (a) acc[i] <= 1'b1;
    else evt[i] <= 1'b1;
    @(posedge core_clk);
    acc <= 3'h0;
    evt <= 4'h0;
    @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  // results taken off the queues as they appear
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rdq.size() == 0) chk("rd_extra", 33'h0, 33'h1);
      else chk("prdata", rdq.pop_front(), {pslverr, prdata});
    end
    if (sop.push) begin
      chk("push_sel", pc, sop.sel);
      pc++;
    end
    if (sop.pull) begin
      chk("pull_sel", 4 - pl, sop.sel);
      pl = (pl == 4) ? 0 : pl + 1;
    end
    if (set_mask) chk("mask_at", 5, pc);
    if (vfetch) begin
      chk("frame", 5, pc);
      chk("busy", 1, busy);
      pc = 0;
      if (vq.size() == 0) chk("vec_extra", 33'h0, {17'h1, vaddr});
      else chk("vector", vq.pop_front(), vaddr);
    end
  end

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {swi_req, rti_req, sei_req, cli_req, cpu_wait, cpu_stop} = '0;
    {evt, acc, errors, compares, cyc, pc, pl} = '0;
    {led_on, ext_drv, keys} = 6'h3f;
    rnd = $urandom(48207);
    // enables written in reset must survive it
    wr(MISC_ADDR, 32'hc0);
    tick(7);
    nrst <= 1'b1;
    chk("pin_oe", 1, pin_oe);
    chk("pin_o", 0, pin_o);
    foreach (RA[i]) rd(RA[i], RA[i] == MISC_ADDR ? 33'hc0 : 0);
    rd(8'hfc, 33'h1_0000_0000);
    rnd = $urandom;
    wr(T16_CTL_ADDR, 32'h0);
    wr(PULLUP_ADDR, {24'h0, rnd[7:0]});
    tick(1);
    chk("pullup_en", rnd[7:0], pullup_en);
    wr(MISC_ADDR, {26'h0, rnd[5:2], 2'b11});
    rd(MISC_ADDR, {27'h0, rnd[5:2], 2'b11});
    chk("pin_oe", 0, pin_oe);
    vq.push_back(VEC_SWI);
    cpu(1'b1);
    wait_q(0);
    cpu(1'b0);
    chk("imask", 1, imask);
    mask(1'b0);
    // edge only: one request per fall
    ext_drv <= 1'b0;
    vq.push_back(VEC_EXT);
    wait_q(0);
    cpu(1'b0);
    tick(40);
    ext_drv <= 1'b1;
    tick(10);
    ext_drv <= 1'b0;
    vq.push_back(VEC_EXT);
    wait_q(0);
    cpu(1'b0);
    // masked request held until unmasked
    ext_drv <= 1'b1;
    mask(1'b1);
    tick(10);
    ext_drv <= 1'b0;
    tick(30);
    vq.push_back(VEC_EXT);
    mask(1'b0);
    wait_q(0);
    cpu(1'b0);
    // level mode repeats while low, then disable blocks it
    vq.push_back(VEC_EXT);
    wr(MISC_ADDR, 32'h2);
    wait_q(0);
    cpu(1'b0);
    vq.push_back(VEC_EXT);
    wait_q(0);
    wr(MISC_ADDR, 32'h1);
    cpu(1'b0);
    ext_drv <= 1'b1;
    tick(30);
    // pull-ups on and stale flags cleared first
    wr(PULLUP_ADDR, 32'hf);
    wr(KEY_FLAG_ADDR, 32'hf);
    for (int k = 0; k < 4; k++) begin
      keys[k] <= 1'b0;
      tick(10);
      rd(KEY_FLAG_ADDR, 33'h1 << k);
      wr(KEY_FLAG_ADDR, 32'h1 << k);
      rd(KEY_FLAG_ADDR, 33'h0);
      keys[k] <= 1'b1;
      tick(10);
    end
    mask(1'b1);
    wr(KEY_EN_ADDR, 32'h4);
    cpu_stop <= 1'b1;
    tick(2);
    chk("wake", 0, wake);
    keys[2] <= 1'b0;
    tick(10);
    chk("wake", 1, wake);
    keys[2] <= 1'b1;
    wr(KEY_EN_ADDR, 32'h0);
    wr(T8_CS_ADDR, 32'h48);
    wr(MISC_ADDR, 32'h81);
    wr(T16_CTL_ADDR, 32'h20);
    chk("t8_run", 1, t8_run);
    strobe(3, 1'b0);
    strobe(0, 1'b0);
    tick(2);
    chk("wake", 0, wake);
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b1;
    tick(2);
    chk("wake", 1, wake);
    cpu_wait <= 1'b0;
    wr(KEY_EN_ADDR, 32'h4);
    vq.push_back(VEC_T16);
    vq.push_back(VEC_T8);
    vq.push_back(VEC_KEY);
    mask(1'b0);
    wait_q(2);
    rd(T16_STS_ADDR, 33'h80);
    strobe(0, 1'b1);
    rd(T16_STS_ADDR, 33'h0);
    cpu(1'b0);
    wait_q(1);
    wr(T8_CS_ADDR, 32'hc8);
    cpu(1'b0);
    wait_q(0);
    wr(KEY_FLAG_ADDR, 32'h4);
    cpu(1'b0);
    wr(MISC_ADDR, 32'hc1);
    for (int i = 1; i < 3; i++) begin
      vq.push_back(VEC_T16);
      strobe(i, 1'b0);
      wait_q(0);
      strobe(i, 1'b1);
      rd(T16_STS_ADDR, 33'h80 >> i);
      strobe(i, 1'b1);
      rd(T16_STS_ADDR, 33'h0);
      cpu(1'b0);
    end
    tick(20);
    chk("rd_left", 0, rdq.size());
    complete_run();
  end
endmodule // testbench
